//--- fdp_ctrl.sv
/*
  Drive parameter access and sub-device level controller: service channel
  decode onto motor and module registers, operation mode, level state
  machine, cycle time checks and interpolation. APB slave for setup.
  Assumes the service engine, target ports and sync share pclk.
*/
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fdp_ctrl #(
  parameter int unsigned MS_CYCLES = fdp_pkg::MS_CYCLES,
  parameter int unsigned SERIES    = fdp_pkg::SERIES_INTEG,
  parameter bit          EXT_RANGE = 1'b1
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 svc_valid,
  input  wire fdp_pkg::fdp_svc_req_s svc_req,
  output logic                      svc_busy,
  output fdp_pkg::fdp_svc_rsp_s     svc_rsp,
  output fdp_pkg::fdp_tgt_req_s     tgt,
  input  wire logic                 tgt_ack,
  input  wire logic [31:0]          tgt_rdata,
  input  wire logic                 tgt_prot_ol,
  input  wire logic                 tgt_prot_pl,
  input  wire logic                 sync_pulse,
  input  wire logic [31:0]          pos_cmd,
  output logic [31:0]               pos_out,
  input  wire logic                 main_power,
  input  wire logic                 torque_on,
  output logic [15:0]               drive_status,
  output logic [15:0]               dev_status,
  output logic                      mon_en,
  output logic [7:0]                op_mode
);

  if (SERIES > fdp_pkg::SERIES_INTEG || MS_CYCLES == 0 ||
      MS_CYCLES > 100000)
  begin : g_chk
    $error("fdp_ctrl: unsupported SERIES or MS_CYCLES");
  end

  typedef enum logic [0:0] {SV_IDLE = 1'b0, SV_WAIT = 1'b1} fdp_svc_e;

  // Bus cycle times per motor series
  function automatic logic bus_ok(input logic [4:0] b);
    case (b)
      5'h01, 5'h02: bus_ok = 1'b1;
      5'h03, 5'h04, 5'h06, 5'h08, 5'h10:
        bus_ok = (SERIES == fdp_pkg::SERIES_INTEG);
      default: bus_ok = 1'b0;
    endcase
  endfunction

  function automatic logic is_mode(input logic [7:0] m);
    is_mode = 1'b0;
    for (int i = 0; i < fdp_pkg::N_MODES; i++)
      if (fdp_pkg::MODE_LIST[i] == m)
        is_mode = 1'b1;
  endfunction

  function automatic fdp_pkg::fdp_cls_e decode(input logic p,
                                               input logic [11:0] n);
    decode = fdp_pkg::CL_NONE;
    if (p && n != 12'h000 && n <= fdp_pkg::MOTOR_LAST)
      decode = fdp_pkg::CL_MOTOR;
    else if (p && EXT_RANGE && n > fdp_pkg::MOTOR_LAST &&
             n <= fdp_pkg::EXT_LAST)
      decode = fdp_pkg::CL_MOTOR;
    else if (p && n >= fdp_pkg::MODULE_FIRST && n <= fdp_pkg::MODULE_LAST)
      decode = fdp_pkg::CL_MODULE;
    else if (!p && n == fdp_pkg::IDN_MODE)
      decode = fdp_pkg::CL_MODE;
    else if (!p && n == fdp_pkg::IDN_DSTAT)
      decode = fdp_pkg::CL_DSTAT;
    else if (!p && n == fdp_pkg::IDN_MODES)
      decode = fdp_pkg::CL_MODES;
    else if (!p && n == fdp_pkg::IDN_ENTER)
      decode = fdp_pkg::CL_ENTER;
    else if (!p && n == fdp_pkg::IDN_EXIT)
      decode = fdp_pkg::CL_EXIT;
    else if (!p && n == fdp_pkg::IDN_INVAL)
      decode = fdp_pkg::CL_INVAL;
    else if (!p && n == fdp_pkg::IDN_SMCTL)
      decode = fdp_pkg::CL_SMCTL;
  endfunction

  logic [4:0]          bus_ms_reg;
  logic [5:0]          mot_ms_reg;
  logic [2:0]          phase_reg;
  logic                refused_reg;
  logic [1:0]          enter_reg;
  logic [1:0]          exit_reg;
  logic [31:0]         smctl_reg;
  logic [1:0]          pwr_meta_reg;
  logic [1:0]          pwr_reg;
  fdp_pkg::fdp_level_e level_reg;
  fdp_pkg::fdp_level_e level_next;
  fdp_svc_e            sv_reg;
  logic                motion_tick;
  logic                bus_tick;
  logic                sync_lost;

  // Motion cycle range and multiple of bus cycle
  wire       bus_good = bus_ok(bus_ms_reg);
  wire       mot_good = bus_good && mot_ms_reg != 6'h00 &&
                        mot_ms_reg <= fdp_pkg::MOT_MS_MAX &&
                        (mot_ms_reg % {1'b0, bus_ms_reg}) == 6'h00;
  wire       cfg_ok   = bus_good && mot_good;
  wire [5:0] ratio    = cfg_ok ? mot_ms_reg / {1'b0, bus_ms_reg} : 6'h01;
  wire [1:0] inval    = {~mot_good, ~bus_good};
  wire       hi_phase = phase_reg >= fdp_pkg::PHASE_OP;
  wire       is_pl    = (level_reg == fdp_pkg::LVL_PL);

  // APB decode and read mux
  wire setup   = psel & ~penable;
  wire acc_wr  = psel & penable & pwrite & pready;
  wire sel_cfg = (paddr == fdp_pkg::OFS_CFG);
  wire sel_ph  = (paddr == fdp_pkg::OFS_PHASE);
  wire sel_st  = (paddr == fdp_pkg::OFS_STAT);
  wire bad_wr  = pwrite & ((sel_cfg & hi_phase) | sel_st |
                 (sel_ph & pwdata[2:0] > fdp_pkg::PHASE_TOP));
  wire apb_err = ~(sel_cfg | sel_ph | sel_st) | bad_wr;
  wire [31:0] rd_mux =
    sel_cfg ? {18'h00000, mot_ms_reg, 3'h0, bus_ms_reg} :
    sel_ph  ? {29'h00000000, phase_reg} :
    sel_st  ? {12'h000, sync_lost, cfg_ok, refused_reg, is_pl,
               drive_status} : 32'h00000000;
  wire wr_cfg = acc_wr & ~pslverr & sel_cfg;
  wire wr_ph  = acc_wr & ~pslverr & sel_ph;
  wire ph_top = pwdata[2:0] == fdp_pkg::PHASE_TOP;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= apb_err;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_ms_reg  <= fdp_pkg::BUS_MS_RST;
      mot_ms_reg  <= fdp_pkg::MOT_MS_RST;
      phase_reg   <= fdp_pkg::PHASE_RST;
      refused_reg <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
      begin
        bus_ms_reg <= pwdata[4:0];
        mot_ms_reg <= pwdata[13:8];
      end
      // Top phase needs a valid cycle setup
      if (wr_ph && ph_top && !cfg_ok)
        refused_reg <= 1'b1;
      else if (wr_ph)
      begin
        phase_reg   <= pwdata[2:0];
        refused_reg <= 1'b0;
      end
    end
  end

  // Service channel decode
  wire fdp_pkg::fdp_cls_e cls = decode(svc_req.prod, svc_req.num);
  wire take   = svc_valid & (sv_reg == SV_IDLE);
  wire wr     = svc_req.write;
  wire [1:0] cmd = svc_req.data[1:0];
  wire is_tgt = (cls == fdp_pkg::CL_MOTOR) | (cls == fdp_pkg::CL_MODULE);
  wire prot   = is_pl ? tgt_prot_pl : tgt_prot_ol;
  wire decoupled = smctl_reg[fdp_pkg::SMCTL_DECOUPLE];
  // Execute on 3 only after 0
  wire ent_run = wr & (cmd == fdp_pkg::CMD_EXEC);
  wire ent_bad = ent_run & ((enter_reg != fdp_pkg::CMD_IDLE) | ~decoupled);
  wire ext_bad = ent_run & ((exit_reg != fdp_pkg::CMD_IDLE) | ~decoupled |
                 ~hi_phase | (inval != 2'b00));
  wire enter_go = take & (cls == fdp_pkg::CL_ENTER) & ent_run & ~ent_bad;
  wire exit_go  = take & (cls == fdp_pkg::CL_EXIT) & ent_run & ~ext_bad;
  wire [2:0] midx = svc_req.data[2:0];
  wire [7:0] mode_at = (midx == 3'h0 || midx > 3'(fdp_pkg::N_MODES)) ?
                       8'(fdp_pkg::N_MODES) :
                       fdp_pkg::MODE_LIST[midx - 3'h1];

  logic        imm_err;
  logic [31:0] imm_data;

  always_comb
  begin
    imm_err  = 1'b0;
    imm_data = 32'h00000000;
    case (cls)
      fdp_pkg::CL_MOTOR, fdp_pkg::CL_MODULE: imm_err = wr & prot;
      fdp_pkg::CL_MODE:
      begin
        imm_err  = wr & (~is_pl | ~is_mode(svc_req.data[7:0]));
        imm_data = {24'h000000, op_mode};
      end
      fdp_pkg::CL_DSTAT:
      begin
        imm_err  = wr;
        imm_data = {16'h0000, drive_status};
      end
      fdp_pkg::CL_MODES:
      begin
        imm_err  = wr;
        imm_data = {24'h000000, mode_at};
      end
      fdp_pkg::CL_ENTER:
      begin
        imm_err  = ent_bad;
        imm_data = {30'h00000000, enter_reg};
      end
      fdp_pkg::CL_EXIT:
      begin
        imm_err  = ext_bad;
        imm_data = {30'h00000000, exit_reg};
      end
      fdp_pkg::CL_INVAL:
      begin
        imm_err  = wr;
        imm_data = {30'h00000000, inval};
      end
      fdp_pkg::CL_SMCTL: imm_data = smctl_reg;
      default: imm_err = 1'b1;
    endcase
  end

  wire go_tgt = take & is_tgt & ~imm_err;
  wire imm_ok = take & ~imm_err;
  wire [8:0] tgt_addr = (cls == fdp_pkg::CL_MODULE) ?
    9'(svc_req.num - fdp_pkg::MODULE_BASE) : svc_req.num[8:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sv_reg   <= SV_IDLE;
      svc_busy <= 1'b0;
      svc_rsp  <= '0;
      tgt      <= '0;
    end
    else
    begin
      svc_rsp.done <= 1'b0;
      if (go_tgt)
      begin
        sv_reg   <= SV_WAIT;
        svc_busy <= 1'b1;
        tgt      <= '{1'b1, wr, cls == fdp_pkg::CL_MODULE, tgt_addr,
                      svc_req.data};
      end
      else if (take)
        svc_rsp <= '{1'b1, imm_err, imm_err ? 32'h00000000 : imm_data};
      else if (sv_reg == SV_WAIT && tgt_ack)
      begin
        sv_reg   <= SV_IDLE;
        svc_busy <= 1'b0;
        tgt.req  <= 1'b0;
        svc_rsp  <= '{1'b1, 1'b0, tgt.we ? 32'h00000000 : tgt_rdata};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_mode   <= fdp_pkg::MODE_RST;
      enter_reg <= fdp_pkg::CMD_IDLE;
      exit_reg  <= fdp_pkg::CMD_IDLE;
      smctl_reg <= 32'h00000000;
    end
    else if (imm_ok && wr)
    begin
      if (cls == fdp_pkg::CL_MODE)
        op_mode <= svc_req.data[7:0];
      if (cls == fdp_pkg::CL_ENTER)
        enter_reg <= cmd;
      if (cls == fdp_pkg::CL_EXIT)
        exit_reg <= cmd;
      if (cls == fdp_pkg::CL_SMCTL)
        smctl_reg <= svc_req.data;
    end
  end

  assign level_next = !decoupled ?
                        (hi_phase ? fdp_pkg::LVL_OL : fdp_pkg::LVL_PL) :
                      !hi_phase ? fdp_pkg::LVL_PL :
                      enter_go  ? fdp_pkg::LVL_PL :
                      exit_go   ? fdp_pkg::LVL_OL : level_reg;

  // Readiness from level, power and torque
  wire [1:0] rdy = is_pl        ? fdp_pkg::RDY_NONE :
                   pwr_reg[1]   ? fdp_pkg::RDY_TORQ :
                   pwr_reg[0]   ? fdp_pkg::RDY_PWR  : fdp_pkg::RDY_MAIN;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_meta_reg <= 2'b00;
      pwr_reg      <= 2'b00;
      level_reg    <= fdp_pkg::LVL_PL;
      drive_status <= 16'h0000;
      dev_status   <= 16'h0000;
      mon_en       <= 1'b0;
    end
    else
    begin
      pwr_meta_reg <= {torque_on, main_power};
      pwr_reg      <= pwr_meta_reg;
      level_reg    <= level_next;
      // Parameter level forces bits 15-14 low
      drive_status <= {rdy, 14'h0000};
      // Operating level monitors, bit 4 low
      mon_en       <= ~is_pl;
      dev_status   <= 16'(is_pl) << fdp_pkg::DEV_LEVEL_BIT;
    end
  end

  // Motion timing locked to the bus cycle
  fdp_cycle #(
    .MS_CYCLES (MS_CYCLES)
  ) u_cycle (
    .pclk        (pclk),
    .presetn     (presetn),
    .sync_pulse  (sync_pulse),
    .bus_ms      (bus_ms_reg),
    .ratio       (ratio),
    .bus_tick    (bus_tick),
    .motion_tick (motion_tick),
    .sync_lost   (sync_lost)
  );

  fdp_interp u_interp (
    .pclk        (pclk),
    .presetn     (presetn),
    .bus_tick    (bus_tick),
    .motion_tick (motion_tick),
    .interp_en   (op_mode[0]),
    .ratio       (ratio),
    .pos_cmd     (pos_cmd),
    .pos_out     (pos_out)
  );

  sequence svc_take_s(fdp_pkg::fdp_cls_e c);
    take && cls == c;
  endsequence

  sequence tgt_issue_s;
    ##1 tgt.req && svc_busy;
  endsequence

  motor_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    svc_take_s(fdp_pkg::CL_MOTOR) ##0 !(wr && prot)
      |-> tgt_issue_s ##0 tgt.addr == $past(svc_req.num[8:0])
          && !tgt.module_sel)
    else $error("motor register mapped wrong");
  module_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    svc_take_s(fdp_pkg::CL_MODULE) ##0 !(wr && prot)
      |-> tgt_issue_s ##0 tgt.module_sel
          && tgt.addr == 9'($past(svc_req.num) - 12'hBB8))
    else $error("module register mapped wrong");
  prot_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_tgt && wr && prot
      |=> svc_rsp.done && svc_rsp.err && !tgt.req)
    else $error("protected write not refused");
  mode_check_a: assert property (@(posedge pclk) disable iff (!presetn)
    svc_take_s(fdp_pkg::CL_MODE) ##0 wr && !is_mode(svc_req.data[7:0])
      |=> svc_rsp.err && $stable(op_mode))
    else $error("bad mode accepted");
  cp4_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ph && ph_top && !cfg_ok && phase_reg != 3'h4
      |=> phase_reg != 3'h4 && refused_reg)
    else $error("top phase entered with bad cycle");
  level_couple_a: assert property (@(posedge pclk) disable iff (!presetn)
    !decoupled |=> level_reg == ($past(hi_phase) ?
                   fdp_pkg::LVL_OL : fdp_pkg::LVL_PL))
    else $error("coupled level wrong");
  enter_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    enter_go |=> is_pl ##1 drive_status[15:14] == 2'b00)
    else $error("enter command did not clear readiness");
  oper_mon_a: assert property (@(posedge pclk) disable iff (!presetn)
    !is_pl |=> mon_en && !dev_status[4])
    else $error("operating level not reported");

endmodule

//--- fdp_cycle.sv
/*
  Bus cycle follower: re-times the master's sync pulse, derives the motion
  tick every ratio bus cycles and flags a missing sync.
  Assumes sync_pulse is a one-cycle pulse from logic on pclk.
*/
`timescale 1ns/1ps
module fdp_cycle #(
  parameter int unsigned MS_CYCLES = fdp_pkg::MS_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sync_pulse,
  input  wire logic [4:0] bus_ms,
  input  wire logic [5:0] ratio,
  output logic            bus_tick,
  output logic            motion_tick,
  output logic            sync_lost
);

  logic [20:0] cnt_reg;
  logic [5:0]  bcnt_reg;
  wire  [20:0] limit  = 21'((32'(bus_ms) + 32'd1) * MS_CYCLES);
  wire         wrap   = (bcnt_reg + 6'h01) >= ratio;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg     <= 21'h000000;
      bcnt_reg    <= 6'h00;
      bus_tick    <= 1'b0;
      motion_tick <= 1'b0;
      sync_lost   <= 1'b0;
    end
    else
    begin
      bus_tick    <= sync_pulse;
      motion_tick <= sync_pulse & wrap;
      if (sync_pulse)
      begin
        cnt_reg   <= 21'h000000;
        bcnt_reg  <= wrap ? 6'h00 : bcnt_reg + 6'h01;
        sync_lost <= 1'b0;
      end
      else if (cnt_reg >= limit)
        sync_lost <= 1'b1;
      else
        cnt_reg <= cnt_reg + 21'h000001;
    end
  end

  motion_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    motion_tick |-> bus_tick)
    else $error("motion tick off the bus cycle");

endmodule

//--- fdp_interp.sv
/*
  Position interpolator: spreads each cyclic position command over the
  bus cycles of one motion cycle, ending exactly on the command.
  Assumes bus_tick and motion_tick come from fdp_cycle.
*/
`timescale 1ns/1ps
module fdp_interp (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        bus_tick,
  input  wire logic        motion_tick,
  input  wire logic        interp_en,
  input  wire logic [5:0]  ratio,
  input  wire logic [31:0] pos_cmd,
  output logic [31:0]      pos_out
);

  logic [31:0] target_reg;
  logic [31:0] step_reg;
  logic [5:0]  left_reg;
  wire  [32:0] diff = 33'($signed(pos_cmd) - $signed(pos_out));
  wire  [32:0] step = 33'($signed(diff) / $signed({27'h0, ratio}));

  // Linear steps, last step snaps to target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_out    <= 32'h00000000;
      target_reg <= 32'h00000000;
      step_reg   <= 32'h00000000;
      left_reg   <= 6'h00;
    end
    else if (motion_tick && interp_en && ratio > 6'h01)
    begin
      target_reg <= pos_cmd;
      step_reg   <= step[31:0];
      pos_out    <= pos_out + step[31:0];
      left_reg   <= ratio - 6'h01;
    end
    else if (bus_tick && left_reg > 6'h01)
    begin
      pos_out  <= pos_out + step_reg;
      left_reg <= left_reg - 6'h01;
    end
    else if (bus_tick && left_reg == 6'h01)
    begin
      pos_out  <= target_reg;
      left_reg <= 6'h00;
    end
    else if (bus_tick)
      pos_out <= pos_cmd;
  end

  interp_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_tick && !motion_tick && left_reg == 6'h01
      |=> pos_out == $past(target_reg))
    else $error("interpolation did not end on command");

endmodule

//--- fdp_pkg.sv
/*
  Shared constants and types for the drive parameter and level controller.
  Assumes a 25 MHz pclk and an APB master with 32-bit data.
*/
package fdp_pkg;

  localparam int unsigned CLK_HZ    = 25000000;
  localparam int unsigned TICK_MS   = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;

  localparam logic [4:0] BUS_MS_RST = 5'h01;
  localparam logic [5:0] MOT_MS_RST = 6'h01;
  localparam logic [5:0] MOT_MS_MAX = 6'h20;
  localparam logic [2:0] PHASE_RST  = 3'h0;
  localparam logic [2:0] PHASE_OP   = 3'h3;
  localparam logic [2:0] PHASE_TOP  = 3'h4;

  localparam int unsigned SERIES_SERVO = 0;
  localparam int unsigned SERIES_INTEG = 1;

  localparam logic [11:0] IDN_MODE  = 12'h020;
  localparam logic [11:0] IDN_DSTAT = 12'h087;
  localparam logic [11:0] IDN_MODES = 12'h124;
  localparam logic [11:0] IDN_ENTER = 12'h1A4;
  localparam logic [11:0] IDN_EXIT  = 12'h1A6;
  localparam logic [11:0] IDN_INVAL = 12'h1A7;
  localparam logic [11:0] IDN_SMCTL = 12'h1A9;

  localparam logic [11:0] MOTOR_LAST = 12'h0FF;
  localparam logic [11:0] EXT_LAST   = 12'h1FF;
  localparam logic [11:0] MODULE_BASE  = 12'hBB8;
  localparam logic [11:0] MODULE_FIRST = 12'hBB9;
  localparam logic [11:0] MODULE_LAST  = 12'hBF7;

  localparam int unsigned N_MODES = 6;
  localparam logic [7:0] MODE_LIST [N_MODES] =
    '{8'h02, 8'h03, 8'h0A, 8'h0B, 8'h42, 8'h43};
  localparam logic [7:0] MODE_RST = 8'h03;

  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_EXEC = 2'h3;
  localparam int unsigned SMCTL_DECOUPLE = 1;
  localparam int unsigned DEV_LEVEL_BIT  = 4;

  localparam logic [1:0] RDY_NONE = 2'b00;
  localparam logic [1:0] RDY_MAIN = 2'b01;
  localparam logic [1:0] RDY_PWR  = 2'b10;
  localparam logic [1:0] RDY_TORQ = 2'b11;

  typedef enum logic [0:0] {LVL_OL = 1'b0, LVL_PL = 1'b1} fdp_level_e;

  typedef enum logic [3:0] {
    CL_NONE   = 4'h0, CL_MOTOR = 4'h1, CL_MODULE = 4'h2,
    CL_MODE   = 4'h3, CL_DSTAT = 4'h4, CL_MODES  = 4'h5,
    CL_ENTER  = 4'h6, CL_EXIT  = 4'h7, CL_INVAL  = 4'h8,
    CL_SMCTL  = 4'h9
  } fdp_cls_e;

  typedef struct packed {
    logic        write;
    logic        prod;
    logic [11:0] num;
    logic [31:0] data;
  } fdp_svc_req_s;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] data;
  } fdp_svc_rsp_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        module_sel;
    logic [8:0]  addr;
    logic [31:0] data;
  } fdp_tgt_req_s;

endpackage

//--- fdp_tgt_model.sv
/*
  Far-side register target: motor and module words, random ack delay.
  Assumes tgt comes from fdp_ctrl and svc_num from the service request, both on pclk.
*/
`timescale 1ns/1ps
module fdp_tgt_model (
  input  wire logic                  pclk,
  input  wire fdp_pkg::fdp_tgt_req_s tgt,
  input  wire logic [11:0]           svc_num,
  output logic                       tgt_ack,
  output logic [31:0]                tgt_rdata,
  output logic                       tgt_prot_ol,
  output logic                       tgt_prot_pl
);
  logic [31:0] mem [1024];
  int          dly;
  assign tgt_prot_ol = svc_num == 12'h007;
  assign tgt_prot_pl = svc_num == 12'h008;
  initial
  begin
    tgt_ack = 1'b0;
    tgt_rdata = 32'h0;
    dly = 0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  always @(posedge pclk)
  begin
    tgt_ack <= 1'b0;
    tgt_rdata <= ~tgt_rdata;
    if (tgt.req && !tgt_ack && dly != 0)
      dly <= dly - 1;
    else if (tgt.req && !tgt_ack)
    begin
      tgt_ack <= 1'b1;
      tgt_rdata <= mem[{tgt.module_sel, tgt.addr}];
      if (tgt.we)
        mem[{tgt.module_sel, tgt.addr}] <= tgt.data;
      dly <= $urandom % 3;
    end
  end
endmodule

//--- tb.sv
/*
  Self-checking bench for fdp_ctrl: APB, service channel, levels.
  Assumes fdp_tgt_model as the register target.
*/
`timescale 1ns/1ps
module tb;
  logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                  penable = 1'b0, pwrite = 1'b0, er;
  logic                  svc_valid = 1'b0, sync_pulse = 1'b0;
  logic                  main_power = 1'b0, pready, pslverr, svc_busy;
  logic                  torque_on = 1'b0, sp_d = 1'b0;
  logic [31:0]           exp_pos = 32'h0;
  logic                  tgt_ack, tgt_prot_ol, tgt_prot_pl, mon_en;
  logic [7:0]            paddr = 8'h00, op_mode;
  logic [31:0]           pwdata = 32'h0, pos_cmd = 32'h0, d, rd;
  logic [31:0]           prdata, pos_out, tgt_rdata;
  logic [15:0]           drive_status, dev_status;
  logic [4:0]            bt [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06,
                                    5'h08, 5'h10, 5'h05, 5'h07};
  int                    ids [6] = '{1, 255, 256, 511, 3001, 3063};
  int                    fails = 0, n_checks = 0, cyc = 0;
  fdp_pkg::fdp_svc_req_s svc_req = '0;
  fdp_pkg::fdp_svc_rsp_s svc_rsp;
  fdp_pkg::fdp_tgt_req_s tgt;
  fdp_ctrl #(.MS_CYCLES(20)) uut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .svc_valid, .svc_req,
    .svc_busy, .svc_rsp, .tgt, .tgt_ack, .tgt_rdata, .tgt_prot_ol,
    .tgt_prot_pl, .sync_pulse, .pos_cmd, .pos_out, .main_power,
    .torque_on, .drive_status, .dev_status, .mon_en, .op_mode);
  fdp_tgt_model tm (.pclk, .tgt, .svc_num(svc_req.num), .tgt_ack,
    .tgt_rdata, .tgt_prot_ol, .tgt_prot_pl);
  always #20 pclk = ~pclk;
  task automatic close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic svc(input logic w, input logic p, input logic [11:0] n,
                     input logic [31:0] v);
    @(posedge pclk);
    svc_valid <= 1'b1;
    svc_req <= '{w, p, n, v};
    @(posedge pclk);
    svc_valid <= 1'b0;
    do @(posedge pclk); while (svc_rsp.done !== 1'b1);
    er = svc_rsp.err;
    rd = svc_rsp.data;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    // Short bus cycle, no speed hazard
    sync_pulse <= cyc % 20 == 0;
    pos_cmd <= $urandom;
    sp_d <= sync_pulse;
    if (sp_d)
      exp_pos <= pos_cmd;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end
  initial
  begin
    void'($urandom(32'h3f4d));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(op_mode, 32'h3);
    chk(dev_status[4], 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 8'h00, {18'h0, 1'b0, bt[i], 3'h0, bt[i]});
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[18], i < 7);
    end
    apb(1'b1, 8'h00, 32'h0302);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[18:17], 32'h1);
    apb(1'b1, 8'h00, 32'h2002);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[18], 32'h1);
    apb(1'b1, 8'h00, 32'h0101);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 32'h1);
    $display("cycle test done");
    for (int i = 0; i < 6; i++)
    begin
      svc(1'b1, 1'b0, fdp_pkg::IDN_MODE,
          {24'($urandom), fdp_pkg::MODE_LIST[i]});
      chk(op_mode, fdp_pkg::MODE_LIST[i]);
      svc(1'b0, 1'b0, fdp_pkg::IDN_MODES, i + 1);
      chk(rd, fdp_pkg::MODE_LIST[i]);
      d = $urandom;
      svc(1'b1, 1'b1, 12'(ids[i]), d);
      chk(tm.mem[ids[i] > 3000 ? ids[i] - 2488 : ids[i]], d);
      svc(1'b0, 1'b1, 12'(ids[i]), 32'h0);
      chk(rd, d);
    end
    svc(1'b1, 1'b0, fdp_pkg::IDN_MODE, 32'h4);
    chk({er, op_mode}, 32'h143);
    svc(1'b1, 1'b1, 12'h008, d);
    chk({er, tm.mem[8]}, 33'h100000000);
    repeat (25) @(posedge pclk);
    chk(pos_out, exp_pos);
    $display("service test done");
    apb(1'b1, 8'h04, 32'h3);
    repeat (3) @(posedge pclk);
    chk({dev_status[4], mon_en, drive_status}, 32'h14000);
    svc(1'b1, 1'b1, 12'h007, d);
    chk({er, tm.mem[7]}, 33'h100000000);
    svc(1'b1, 1'b0, fdp_pkg::IDN_SMCTL, 32'h2);
    svc(1'b1, 1'b0, fdp_pkg::IDN_ENTER, 32'h0);
    svc(1'b1, 1'b0, fdp_pkg::IDN_ENTER, 32'h3);
    repeat (3) @(posedge pclk);
    chk({er, dev_status[4], drive_status}, 32'h10000);
    svc(1'b1, 1'b1, 12'h007, d);
    chk({er, tm.mem[7]}, d);
    svc(1'b1, 1'b0, fdp_pkg::IDN_EXIT, 32'h0);
    svc(1'b1, 1'b0, fdp_pkg::IDN_EXIT, 32'h3);
    main_power <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({er, mon_en, drive_status[15:14]}, 32'h6);
    svc(1'b1, 1'b0, fdp_pkg::IDN_EXIT, 32'h3);
    chk(er, 32'h1);
    torque_on <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(drive_status[15:14], 32'h3);
    $display("level test done");
    close_out();
  end
endmodule
